/* dv/odp_master_model.sv */
`timescale 1ns/1ps
module odp_master_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic rx_valid,
  output logic rx_first,
  output logic [7:0] rx_byte,
  output logic rx_end,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [1:0] pace_ff;
  logic [8:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_byte = 8'hA5;
    rx_end = 1'b0;
  end

  // One byte a clock, bytes already in wire order: header fields high byte first, CRC low byte first
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_byte <= f[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    // Released line must not keep showing the last byte
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    @(posedge pclk);
    rx_end <= 1'b0;
  endtask

  // Slow mode takes one reply byte in three cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_ff <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      pace_ff <= (pace_ff == 2'h2) ? 2'h0 : pace_ff + 2'h1;
      tx_ready <= !slow || (pace_ff == 2'h2);
      if (tx_valid && tx_ready) got.push_back({tx_last, tx_byte});
    end
  end
endmodule // odp_master_model

/* dv/test_object_dictionary_frame_parser.sv */
`timescale 1ns/1ps
`include "odp_map.svh"
module test_object_dictionary_frame_parser;
  import odp_pkg::*;
  typedef logic [7:0] odp_bq_t[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
  logic rx_valid, rx_first, rx_end, od_req_valid, od_wr_valid, od_fail, od_rd_ready;
  logic od_done = 1'b0;
  logic od_rd_valid = 1'b0;
  logic [7:0] od_rd_byte = 8'h00;
  logic tx_valid, tx_last, tx_ready, irq;
  logic [7:0] paddr, rx_byte, od_wr_byte, od_wr_idx, od_rd_len, tx_byte;
  logic [31:0] pwdata, prdata, od_abort_code, d;
  logic [2:0] wait_cnt = 3'h0;
  odp_od_req_t od_req, req_seen;
  odp_bq_t rd_q, wr_q, pre, x, none;
  int fails, check_count;
  logic [7:0] t_c1[10] = '{8'h04, 8'h02, 8'h10, 8'h08, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_rs[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] t_nd[10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01};
  logic [15:0] t_ct[10] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h00FE, 16'h1, 16'h1};
  logic [31:0] t_cd[10] = '{`ODP_E_UNSUPP, `ODP_E_UNSUPP, `ODP_E_CMD, `ODP_E_CMD, `ODP_E_CMD,
                            `ODP_E_PARAM, `ODP_E_PARAM, `ODP_E_LONG, `ODP_E_LEN, `ODP_E_CMD};

  odp_parser dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .rx_valid, .rx_first, .rx_byte, .rx_end, .od_req_valid, .od_req, .od_wr_valid, .od_wr_byte, .od_wr_idx,
    .od_done, .od_fail, .od_abort_code, .od_rd_len, .od_rd_valid, .od_rd_byte, .od_rd_ready,
    .tx_valid, .tx_byte, .tx_last, .tx_ready, .irq);
  odp_master_model m (.pclk, .presetn, .slow, .rx_valid, .rx_first, .rx_byte, .rx_end,
    .tx_valid, .tx_byte, .tx_last, .tx_ready);

  always #20 pclk = ~pclk;

  task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Dictionary stand-in: answers a few cycles after each request
  always @(posedge pclk) begin
    od_done <= 1'b0;
    if (od_req_valid) begin
      req_seen <= od_req;
      wait_cnt <= 3'h3;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
      od_done <= (wait_cnt == 3'h1);
    end
    if (od_wr_valid) begin
      chk("data index", od_wr_idx, wr_q.size());
      wr_q.push_back(od_wr_byte);
    end
    if (od_rd_valid && od_rd_ready) void'(rd_q.pop_front());
    od_rd_valid <= (rd_q.size() != 0);
    od_rd_byte <= (rd_q.size() != 0) ? rd_q[0] : ~od_rd_byte;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic odp_bq_t addcrc(input odp_bq_t q);
    logic [15:0] c;
    c = `ODP_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `ODP_CRC_POLY) : (c >> 1);
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction

  function automatic odp_bq_t head(input odp_bq_t p, input logic [7:0] node, input logic [15:0] idx);
    return {8'h05, 8'h2B, 8'h0D, p, node, idx[15:8], idx[7:0], 8'h00, 8'h00, 8'h00};
  endfunction

  // Sends one request and compares the whole reply, CRC and last flag included
  task automatic run(input odp_bq_t p, input logic [7:0] node, input logic [15:0] idx, input logic [15:0] cnt,
                     input odp_bq_t wdat, input odp_bq_t rdat, input logic [31:0] cd);
    odp_bq_t h, q, r;
    int n;
    h = head(p, node, idx);
    rd_q = rdat;
    od_rd_len <= 8'(rdat.size());
    if (cd != 32'h0)
      r = {8'h05, 8'hAB, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE, cd[31:24], cd[23:16], cd[15:8], cd[7:0]};
    else
      r = {h, 8'h00, 8'(rdat.size()), rdat};
    q = {h, cnt[15:8], cnt[7:0], wdat};
    m.send(addcrc(q));
    r = addcrc(r);
    n = 0;
    while (m.got.size() < r.size() && n < 600) begin
      @(posedge pclk);
      n++;
    end
    repeat (6) @(posedge pclk);
    chk("reply length", m.got.size(), r.size());
    foreach (r[i]) chk("reply byte", m.got[i], {i == r.size() - 1, r[i]});
    m.got.delete();
  endtask

  initial begin
    watchdog();
  end

  task automatic watchdog;
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    slow = 1'b0;
    {psel, penable, pwrite, od_fail} = '0;
    {paddr, pwdata, od_abort_code, od_rd_len} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ODP_CTRL_OFS, 32'h0);
    chk("ctrl reset", d, 32'h00000501);
    apb(1'b0, `ODP_IRQ_MASK_OFS, 32'h0);
    chk("mask reset", d, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {e, d}, {1'b1, 32'h0});
    run('{8'h00, 8'h00}, 8'h01, 16'h6041, 16'h0002, none, '{8'h37, 8'h06}, 32'h0);
    chk("request", req_seen, {3'b000, 8'h00, 8'h01, 16'h6041, 8'h00, 16'h0, 16'h0002});
    apb(1'b0, `ODP_IRQ_STAT_OFS, 32'h0);
    chk("irq status", d[3:0], 4'h3);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, `ODP_IRQ_MASK_OFS, 32'h2);
    @(negedge pclk);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, `ODP_IRQ_STAT_OFS, 32'hF);
    @(negedge pclk);
    chk("irq cleared", irq, 1'b0);
    // Slow master while a four-byte value is written
    @(posedge pclk);
    slow <= 1'b1;
    run('{8'h01, 8'h00}, 8'h01, 16'h2031, 16'h0004, '{8'hE8, 8'h03, 8'h00, 8'h00}, none, 32'h0);
    slow <= 1'b0;
    chk("write data", {wr_q[0], wr_q[1], wr_q[2], wr_q[3]}, 32'hE8030000);
    chk("request", req_seen, {3'b100, 8'h00, 8'h01, 16'h2031, 8'h00, 16'h0, 16'h0004});
    run('{8'hE0, 8'h00, 8'h00, 8'h5A}, 8'h7F, 16'h1234, 16'h00FD, none, none, 32'h0);
    chk("request", req_seen, {3'b011, 8'h5A, 8'h7F, 16'h1234, 8'h00, 16'h0, 16'h00FD});
    apb(1'b0, `ODP_STATUS_OFS, 32'h0);
    chk("status", d, 32'h0002E001);
    for (int k = 0; k < 10; k++) begin
      pre = '{t_c1[k], t_rs[k]};
      if (t_c1[k][6]) pre.insert(1, 8'h01);
      x = none;
      if (k == 8) x.push_back(8'h55);
      run(pre, t_nd[k], 16'h6041, t_ct[k], x, none, t_cd[k]);
      apb(1'b0, `ODP_ERR_OFS, 32'h0);
      chk("error code", d, t_cd[k]);
    end
    apb(1'b0, `ODP_IRQ_STAT_OFS, 32'h0);
    chk("exception flag", d[2], 1'b1);
    od_fail <= 1'b1;
    od_abort_code <= 32'hFFFF0008;
    run('{8'h00, 8'h00}, 8'h01, 16'h6061, 16'h0001, none, none, 32'hFFFF0008);
    od_fail <= 1'b0;
    // Disabled block ignores its own address; a failed broadcast is dropped silently
    apb(1'b1, `ODP_CTRL_OFS, 32'h00000500);
    apb(1'b0, `ODP_CTRL_OFS, 32'h0);
    chk("ctrl write", d, 32'h00000500);
    x = head('{8'h00, 8'h00}, 8'h01, 16'h6041);
    x.push_back(8'h00);
    x.push_back(8'h01);
    m.send(addcrc(x));
    apb(1'b1, `ODP_CTRL_OFS, 32'h00000501);
    apb(1'b1, `ODP_IRQ_STAT_OFS, 32'hF);
    x = head('{8'h00, 8'h01}, 8'h01, 16'h6041);
    x[0] = 8'h00;
    x.push_back(8'h00);
    x.push_back(8'h01);
    m.send(addcrc(x));
    repeat (40) @(posedge pclk);
    chk("silent frames", m.got.size(), 0);
    apb(1'b0, `ODP_IRQ_STAT_OFS, 32'h0);
    chk("drop flag", d[3:0], 4'h8);
    wrap_up();
  end
endmodule // test_object_dictionary_frame_parser

/* include/odp_map.svh */
`ifndef ODP_MAP_SVH
`define ODP_MAP_SVH

// APB register offsets (byte addresses)
`define ODP_CTRL_OFS 8'h00
`define ODP_STATUS_OFS 8'h04
`define ODP_IRQ_STAT_OFS 8'h08
`define ODP_IRQ_MASK_OFS 8'h0C
`define ODP_ERR_OFS 8'h10

// Control register layout and reset values
`define ODP_CTRL_EN_BIT 0
`define ODP_CTRL_ADDR_LSB 8
`define ODP_CTRL_EN_RST 1'b1
`define ODP_ADDR_RST 8'h05
`define ODP_BCAST_ADDR 8'h00

// Interrupt status bits
`define ODP_IRQ_REQ 0
`define ODP_IRQ_REPLY 1
`define ODP_IRQ_EXC 2
`define ODP_IRQ_DROP 3
`define ODP_IRQ_W 4

// Frame constants
`define ODP_FC 8'h2B
`define ODP_MEI 8'h0D
`define ODP_FC_ERR_BIT 8'h80
`define ODP_EXC_EXT 8'hFF
`define ODP_EXC_LEN_HI 8'h00
`define ODP_EXC_LEN_LO 8'h06
`define ODP_EXC_TYPE 8'hCE
`define ODP_EXC_FRAME 9'd13
`define ODP_NODE_MIN 8'h01
`define ODP_NODE_MAX 8'h7F
`define ODP_CNT_MAX 16'h00FD
`define ODP_HDR_DEPTH 16
`define ODP_CTRL_POS 9'd3

// Control byte 1: field bit N sits at byte bit 7-N
`define ODP_B_MULTI 7
`define ODP_B_EXT 6
`define ODP_B_CNTR 5
`define ODP_B_RSV3 4
`define ODP_B_RSV4 3
`define ODP_B_NETID 2
`define ODP_B_ENC 1
`define ODP_B_ACCESS 0

// Object access error codes
`define ODP_E_UNSUPP 32'hFFFF1003
`define ODP_E_CMD 32'hFFFF0003
`define ODP_E_PARAM 32'hFFFF000E
`define ODP_E_LEN 32'hFFFF0011
`define ODP_E_LONG 32'hFFFF0012

// CRC
`define ODP_CRC_INIT 16'hFFFF
`define ODP_CRC_POLY 16'hA001

`endif

/* include/odp_pkg.sv */
package odp_pkg;

  typedef enum logic [3:0] {
    ODP_IDLE = 4'h1,
    ODP_RX = 4'h2,
    ODP_WAIT = 4'h4,
    ODP_TX = 4'h8
  } odp_state_t;

  typedef struct packed {
    logic write;
    logic multi;
    logic cntr_present;
    logic [7:0] counter;
    logic [7:0] node;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [15:0] start;
    logic [15:0] count;
  } odp_od_req_t;

endpackage

/* rtl/odp_crc16.sv */
`timescale 1ns/1ps
`include "odp_map.svh"

module odp_crc16 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc
);
  import odp_pkg::*;

  logic [15:0] crc_ff;
  logic [15:0] stage [0:8];

  assign stage[0] = crc_ff;

  // Reflected polynomial, one input bit per step, LSB first
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign stage[i+1] = (stage[i][0] ^ din[i]) ? ((stage[i] >> 1) ^ `ODP_CRC_POLY) : (stage[i] >> 1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ff <= `ODP_CRC_INIT;
    end else if (clr) begin
      crc_ff <= `ODP_CRC_INIT;
    end else if (en) begin
      crc_ff <= stage[8];
    end
  end

  assign crc = crc_ff;

endmodule // odp_crc16

/* rtl/odp_parser.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "odp_map.svh"
// What this block does
// - Control bit 0 is byte MSB
// - Extended bit adds second control byte
// - Bit 0 flags multi-message transfer part
// - Bit 2 means counter byte present
// - Bit 7: zero read, one write
// - Node, index, subindex, start, count, then data
// - Write reply echoes header, count zero
// - Failure reply: FC+80h, FFh, length, CEh, code
module odp_parser (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  output logic od_req_valid,
  output odp_pkg::odp_od_req_t od_req,
  output logic od_wr_valid,
  output logic [7:0] od_wr_byte,
  output logic [7:0] od_wr_idx,
  input wire logic od_done,
  input wire logic od_fail,
  input wire logic [31:0] od_abort_code,
  input wire logic [7:0] od_rd_len,
  input wire logic od_rd_valid,
  input wire logic [7:0] od_rd_byte,
  output logic od_rd_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  output logic irq
);
  import odp_pkg::*;

  odp_state_t st_ff;
  odp_od_req_t req_ff;
  logic [8:0] pos_ff, base_ff;
  logic ext_ff, bcast_ff, err_flag_ff, exc_ff, req_v_ff;
  logic [31:0] err_ff, err_last_ff, prdata_ff;
  logic [7:0] dlen_ff, ctrl1_ff, own_addr_ff, tbyte_ff, wbyte_ff, widx_ff;
  logic ctrl_en_ff, tvalid_ff, tlast_ff, tcrc_ff, wvalid_ff;
  logic [8:0] tidx_ff;
  logic [`ODP_IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [7:0] hdr_mem [`ODP_HDR_DEPTH];
  logic [15:0] crc;

  // Receive side decode
  wire addr_hit = (rx_byte == own_addr_ff) | (rx_byte == `ODP_BCAST_ADDR);
  wire frame_start = rx_valid & rx_first & ctrl_en_ff & ((st_ff == ODP_IDLE) | (st_ff == ODP_RX));
  wire busy_drop = rx_valid & rx_first & ((st_ff == ODP_WAIT) | (st_ff == ODP_TX));
  wire rx_take = rx_valid & ~rx_first & (st_ff == ODP_RX);
  wire not_ours = rx_take & (((pos_ff == 9'd1) & (rx_byte != `ODP_FC)) | ((pos_ff == 9'd2) & (rx_byte != `ODP_MEI)));
  wire f_ctrl1 = rx_take & (pos_ff == `ODP_CTRL_POS);
  wire f_ctrl2 = rx_take & ext_ff & (pos_ff == 9'd4);
  wire f_rsvd = rx_take & (pos_ff == 9'd4 + {8'd0, ext_ff});
  wire f_cntr = rx_take & req_ff.cntr_present & (pos_ff == 9'd5 + {8'd0, ext_ff});
  wire f_body = rx_take & (pos_ff > `ODP_CTRL_POS) & (pos_ff >= base_ff);
  wire [8:0] q = pos_ff - base_ff;
  wire [15:0] cnt_full = {req_ff.count[15:8], rx_byte};
  wire f_data = f_body & req_ff.write & (q >= 9'd8) & (q < 9'd8 + req_ff.count[8:0]);
  wire [8:0] wr_bytes = req_ff.write ? req_ff.count[8:0] : 9'd0;
  wire [8:0] exp_len = base_ff + 9'd10 + wr_bytes;
  wire len_bad = (pos_ff <= `ODP_CTRL_POS) | (pos_ff != exp_len);
  wire rx_done = (st_ff == ODP_RX) & rx_end & ~frame_start;
  wire rx_fail = err_flag_ff | len_bad;
  wire [31:0] rx_code = err_flag_ff ? err_ff : `ODP_E_LEN;

  // First error in a frame wins; later ones are not reported
  logic new_err;
  logic [31:0] new_code;
  always_comb begin
    new_err = 1'b1;
    new_code = `ODP_E_CMD;
    if (f_ctrl1 & (rx_byte[`ODP_B_NETID] | rx_byte[`ODP_B_ENC])) begin
      new_code = `ODP_E_UNSUPP;
    end else if (f_ctrl1 & (rx_byte[`ODP_B_RSV3] | rx_byte[`ODP_B_RSV4])) begin
      new_code = `ODP_E_CMD;
    end else if ((f_ctrl2 | f_rsvd) & (rx_byte != 8'h00)) begin
      new_code = `ODP_E_CMD;
    end else if (f_body & (q == 9'd0) & ((rx_byte < `ODP_NODE_MIN) | (rx_byte > `ODP_NODE_MAX))) begin
      new_code = `ODP_E_PARAM;
    end else if (f_body & (q == 9'd7) & (cnt_full > `ODP_CNT_MAX)) begin
      new_code = `ODP_E_LONG;
    end else begin
      new_err = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ODP_IDLE;
    end else begin
      unique case (st_ff)
        ODP_IDLE: if (frame_start & addr_hit) st_ff <= ODP_RX;
        ODP_RX: begin
          if (frame_start) st_ff <= addr_hit ? ODP_RX : ODP_IDLE;
          else if (not_ours) st_ff <= ODP_IDLE;
          else if (rx_done) st_ff <= rx_fail ? (bcast_ff ? ODP_IDLE : ODP_TX) : ODP_WAIT;
        end
        ODP_WAIT: if (od_done) st_ff <= bcast_ff ? ODP_IDLE : ODP_TX;
        ODP_TX: if (tvalid_ff & tx_ready & tlast_ff) st_ff <= ODP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= 9'd0;
      bcast_ff <= 1'b0;
      err_flag_ff <= 1'b0;
      err_ff <= 32'h0000_0000;
    end else if (frame_start) begin
      pos_ff <= 9'd1;
      bcast_ff <= rx_byte == `ODP_BCAST_ADDR;
      err_flag_ff <= 1'b0;
    end else if (rx_take) begin
      pos_ff <= (pos_ff == 9'h1FF) ? pos_ff : pos_ff + 9'd1;
      if (new_err & ~err_flag_ff) begin
        err_flag_ff <= 1'b1;
        err_ff <= new_code;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= '0;
      ext_ff <= 1'b0;
      base_ff <= 9'd0;
      ctrl1_ff <= 8'h00;
    end else if (f_ctrl1) begin
      ctrl1_ff <= rx_byte;
      req_ff.multi <= rx_byte[`ODP_B_MULTI];
      ext_ff <= rx_byte[`ODP_B_EXT];
      req_ff.cntr_present <= rx_byte[`ODP_B_CNTR];
      req_ff.write <= rx_byte[`ODP_B_ACCESS];
      req_ff.counter <= 8'h00;
      // Node sits after control, reserved and optional counter bytes
      base_ff <= 9'd5 + {8'd0, rx_byte[`ODP_B_EXT]} + {8'd0, rx_byte[`ODP_B_CNTR]};
    end else if (f_cntr) begin
      req_ff.counter <= rx_byte;
    end else if (f_body) begin
      unique case (q)
        9'd0: req_ff.node <= rx_byte;
        9'd1: req_ff.index[15:8] <= rx_byte;
        9'd2: req_ff.index[7:0] <= rx_byte;
        9'd3: req_ff.subindex <= rx_byte;
        9'd4: req_ff.start[15:8] <= rx_byte;
        9'd5: req_ff.start[7:0] <= rx_byte;
        9'd6: req_ff.count[15:8] <= rx_byte;
        9'd7: req_ff.count[7:0] <= rx_byte;
        default: ;
      endcase
    end
  end

  // Header bytes are kept so the reply can echo them unchanged
  always_ff @(posedge pclk) begin
    if (frame_start) begin
      hdr_mem[0] <= rx_byte;
    end else if (rx_take & (pos_ff < `ODP_HDR_DEPTH)) begin
      hdr_mem[pos_ff[3:0]] <= rx_byte;
    end
  end

  // Write data streams out as received; the dictionary commits only on od_req_valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wvalid_ff <= 1'b0;
      wbyte_ff <= 8'h00;
      widx_ff <= 8'h00;
    end else begin
      wvalid_ff <= f_data;
      if (f_data) begin
        wbyte_ff <= rx_byte;
        widx_ff <= q[7:0] - 8'd8;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_v_ff <= 1'b0;
      exc_ff <= 1'b0;
      dlen_ff <= 8'h00;
      err_last_ff <= 32'h0000_0000;
    end else begin
      req_v_ff <= rx_done & ~rx_fail;
      if (rx_done) begin
        exc_ff <= rx_fail;
        dlen_ff <= 8'h00;
        if (rx_fail) err_last_ff <= rx_code;
      end else if ((st_ff == ODP_WAIT) & od_done) begin
        exc_ff <= od_fail;
        dlen_ff <= req_ff.write ? 8'h00 : od_rd_len;
        if (od_fail) err_last_ff <= od_abort_code;
      end
    end
  end

  // Transmit side: one byte per slot, loaded into a flop before it is offered
  wire [8:0] n_hdr = base_ff + 9'd6;
  wire [8:0] t_tot = exc_ff ? `ODP_EXC_FRAME : n_hdr + 9'd4 + {1'b0, dlen_ff};
  wire [8:0] t_crc = t_tot - 9'd2;
  wire t_crc_lo = tidx_ff == t_crc;
  wire t_crc_hi = tidx_ff == t_crc + 9'd1;
  wire t_data = ~exc_ff & (tidx_ff >= n_hdr + 9'd2) & (tidx_ff < t_crc);
  wire t_load = (st_ff == ODP_TX) & ~tvalid_ff & (~t_data | od_rd_valid);
  wire t_hand = tvalid_ff & tx_ready;
  wire tx_enter = ((st_ff == ODP_RX) & rx_done & rx_fail & ~bcast_ff) | ((st_ff == ODP_WAIT) & od_done & ~bcast_ff);
  wire [7:0] hdr_byte = hdr_mem[tidx_ff[3:0]];
  wire [7:0] norm_byte = (tidx_ff < n_hdr) ? hdr_byte :
                         (tidx_ff == n_hdr) ? 8'h00 :
                         (tidx_ff == n_hdr + 9'd1) ? dlen_ff : od_rd_byte;
  logic [7:0] exc_byte;
  always_comb begin
    unique case (tidx_ff[3:0])
      4'h0: exc_byte = hdr_mem[0];
      4'h1: exc_byte = hdr_mem[1] | `ODP_FC_ERR_BIT;
      4'h2: exc_byte = `ODP_EXC_EXT;
      4'h3: exc_byte = `ODP_EXC_LEN_HI;
      4'h4: exc_byte = `ODP_EXC_LEN_LO;
      4'h5: exc_byte = `ODP_MEI;
      4'h6: exc_byte = `ODP_EXC_TYPE;
      4'h7: exc_byte = err_last_ff[31:24];
      4'h8: exc_byte = err_last_ff[23:16];
      4'h9: exc_byte = err_last_ff[15:8];
      default: exc_byte = err_last_ff[7:0];
    endcase
  end
  wire [7:0] slot_byte = t_crc_lo ? crc[7:0] : t_crc_hi ? crc[15:8] : exc_ff ? exc_byte : norm_byte;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tidx_ff <= 9'd0;
      tvalid_ff <= 1'b0;
      tbyte_ff <= 8'h00;
      tlast_ff <= 1'b0;
      tcrc_ff <= 1'b0;
    end else if (tx_enter) begin
      tidx_ff <= 9'd0;
    end else if (t_load) begin
      tvalid_ff <= 1'b1;
      tbyte_ff <= slot_byte;
      tlast_ff <= tidx_ff == t_tot - 9'd1;
      tcrc_ff <= t_crc_lo | t_crc_hi;
    end else if (t_hand) begin
      tvalid_ff <= 1'b0;
      tidx_ff <= tidx_ff + 9'd1;
    end
  end

  odp_crc16 u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .clr(tx_enter),
    .en(t_hand & ~tcrc_ff),
    .din(tbyte_ff),
    .crc(crc)
  );

  assign od_rd_ready = (st_ff == ODP_TX) & ~tvalid_ff & t_data;
  assign tx_valid = tvalid_ff;
  assign tx_byte = tbyte_ff;
  assign tx_last = tlast_ff;
  assign od_req_valid = req_v_ff;
  assign od_req = req_ff;
  assign od_wr_valid = wvalid_ff;
  assign od_wr_byte = wbyte_ff;
  assign od_wr_idx = widx_ff;

  // APB slave, no wait states
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire sel_ctrl = paddr == `ODP_CTRL_OFS;
  wire sel_stat = paddr == `ODP_STATUS_OFS;
  wire sel_istat = paddr == `ODP_IRQ_STAT_OFS;
  wire sel_imask = paddr == `ODP_IRQ_MASK_OFS;
  wire sel_err = paddr == `ODP_ERR_OFS;
  wire sel_any = sel_ctrl | sel_stat | sel_istat | sel_imask | sel_err;
  wire [31:0] rd_ctrl = {16'h0000, own_addr_ff, 7'h00, ctrl_en_ff};
  wire [31:0] rd_stat = {14'h0000, req_ff.multi, req_ff.write, ctrl1_ff, 4'h0, st_ff};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl : sel_stat ? rd_stat :
                       sel_istat ? {28'h0000000, irq_stat_ff} :
                       sel_imask ? {28'h0000000, irq_mask_ff} :
                       sel_err ? err_last_ff : 32'h0000_0000;
  wire reply_end = t_hand & tlast_ff;
  logic [`ODP_IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`ODP_IRQ_REQ] = req_v_ff;
    ev[`ODP_IRQ_REPLY] = reply_end & ~exc_ff;
    ev[`ODP_IRQ_EXC] = reply_end & exc_ff;
    ev[`ODP_IRQ_DROP] = busy_drop | (rx_done & rx_fail & bcast_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= `ODP_CTRL_EN_RST;
      own_addr_ff <= `ODP_ADDR_RST;
      irq_mask_ff <= '0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (apb_setup) prdata_ff <= rd_mux;
      if (apb_wr & sel_ctrl) begin
        ctrl_en_ff <= pwdata[`ODP_CTRL_EN_BIT];
        own_addr_ff <= pwdata[`ODP_CTRL_ADDR_LSB +: 8];
      end
      if (apb_wr & sel_imask) irq_mask_ff <= pwdata[`ODP_IRQ_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((apb_wr & sel_istat) ? pwdata[`ODP_IRQ_W-1:0] : '0)) | ev;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~sel_any;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ctrl_bit_order_a: assert property (f_ctrl1 |=> req_ff.multi == $past(rx_byte[7]))
    else $error("control bit 0 not taken from byte MSB");
  ext_len_a: assert property (f_ctrl1 |=> base_ff == 9'd5 + {8'd0, $past(rx_byte[6])} + {8'd0, $past(rx_byte[5])})
    else $error("node offset ignores extended control length");
  multi_flag_a: assert property (req_v_ff |-> od_req.multi == ctrl1_ff[`ODP_B_MULTI])
    else $error("multi-message flag not passed with request");
  cntr_opt_a: assert property (f_cntr |=> od_req.counter == $past(rx_byte))
    else $error("counter byte not captured");
  access_dir_a: assert property (od_wr_valid |-> od_req.write)
    else $error("write data streamed for a read request");
  field_range_a: assert property (req_v_ff |-> od_req.count <= `ODP_CNT_MAX && od_req.node >= `ODP_NODE_MIN
                                  && od_req.node <= `ODP_NODE_MAX)
    else $error("request passed with node or count out of range");
  write_reply_a: assert property (tvalid_ff && !exc_ff && req_ff.write && tidx_ff == n_hdr + 9'd1 |-> tbyte_ff == 8'h00
                                  && t_tot == n_hdr + 9'd4)
    else $error("write reply count not zero");
  rsvd_reject_a: assert property (f_ctrl1 && rx_byte[`ODP_B_RSV3] && !err_flag_ff |=> err_flag_ff)
    else $error("reserved control bit accepted");
  lsb_first_a: assert property (f_data |=> od_wr_valid && od_wr_byte == $past(rx_byte) && od_wr_idx == $past(q[7:0]) - 8'd8)
    else $error("write data not forwarded in arrival order");
  exc_frame_a: assert property (tvalid_ff && exc_ff && tidx_ff == 9'd2 |-> tbyte_ff == `ODP_EXC_EXT)
    else $error("exception frame lacks extended code");
  exc_type_a: assert property (tvalid_ff && exc_ff && tidx_ff == 9'd6 |-> tbyte_ff == `ODP_EXC_TYPE && t_tot == 9'd13)
    else $error("exception frame type byte wrong");

endmodule // odp_parser
